// ---- rtl/rar_pkg.sv ----
// =====================================================================
// constants for the remote target alias remap block
// =====================================================================
// holds offsets, slot layout and reset values shared by the rtl files.
// assumes an 8-bit register address space reached from the i2c target.
package rar_pkg;

    // =================================================================
    // geometry
    // =================================================================
    localparam int NUM_PORTS = 4;
    localparam int NUM_SLOTS = 8;

    // =================================================================
    // register offsets
    // =================================================================
    localparam logic [7:0] PORT_SEL_OFS = 8'h4c;
    localparam logic [7:0] TGT_BASE     = 8'h5d; // target slot 0
    localparam logic [7:0] TGT_END      = 8'h64; // target slot 7
    localparam logic [7:0] TGT_SLOT7    = 8'h64;
    localparam logic [7:0] ALIAS_BASE   = 8'h65; // alias slot 0
    localparam logic [7:0] ALIAS_SLOT1  = 8'h66;
    localparam logic [7:0] ALIAS_SLOT2  = 8'h67;
    localparam logic [7:0] ALIAS_END    = 8'h6c; // alias slot 7

    // =================================================================
    // fields and reset values
    // =================================================================
    localparam int         ADDR_MSB     = 7;     // address field 7:1
    localparam int         ADDR_LSB     = 1;
    localparam int         AUTO_ACK_BIT = 0;
    localparam logic [7:0] PSEL_MASK    = 8'h03; // port number bits
    localparam logic [7:0] PORT_SEL_RST = 8'h00;
    localparam logic [7:0] SLOT_RST     = 8'h00;
    localparam logic [6:0] ADDR_OFF     = 7'h00; // disabled alias

endpackage

// ---- rtl/rar_alias_match.sv ----
// =====================================================================
// alias decoder for one receive port
// =====================================================================
// compares an incoming 7-bit address with the eight alias fields.
// assumes the caller registers the result; this module is pure logic.
`timescale 1ns/100ps

module rar_alias_match (
    // alias table of the addressed port
    input  wire logic [7:0][7:0] alias_tbl,
    // incoming address
    input  wire logic [6:0]      addr,
    // result
    output logic                 hit,
    output logic [2:0]           slot
);

    logic [7:0] slot_hit;

    // =================================================================
    // per-slot compare
    // =================================================================
    // a zero field is skipped so a general call never reaches a target
    for (genvar i = 0; i < rar_pkg::NUM_SLOTS; i++) begin : g_cmp
        assign slot_hit[i] =
            (alias_tbl[i][7:1] != rar_pkg::ADDR_OFF) &&
            (alias_tbl[i][7:1] == addr);
    end

    // lowest slot wins when software programs the same alias twice
    always_comb begin
        hit  = 1'b0;
        slot = 3'h0;
        for (int i = rar_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
            if (slot_hit[i]) begin
                hit  = 1'b1;
                slot = 3'(i);
            end
        end
    end

endmodule

// ---- rtl/rar_remap.sv ----
// =====================================================================
// remote target alias remap, per receive port
// =====================================================================
// holds the alias and target tables of every port, serves register
// reads and writes, and remaps local i2c transactions onto the link.
// assumes the i2c target front end and the control channel run on
// clk_sys and present one-cycle strobes; only the reset rstn is asynchronous.
`timescale 1ns/100ps

module rar_remap (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // register access from the i2c target
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd,
    output logic            reg_rvalid,
    output logic [7:0]      reg_rdata,
    // local transaction address phase
    input  wire logic       txn_valid,
    input  wire logic [1:0] txn_port,
    input  wire logic [6:0] txn_addr,
    input  wire logic       txn_rnw,
    // forwarded transaction toward the serializer
    output logic            fwd_valid,
    output logic [1:0]      fwd_port,
    output logic [6:0]      fwd_addr,
    output logic            fwd_rnw,
    output logic [2:0]      fwd_slot,
    output logic            fwd_auto_ack,
    output logic            txn_miss,
    // acknowledge path
    input  wire logic       remote_ack_valid,
    input  wire logic       remote_ack,
    output logic            host_ack_valid,
    output logic            host_ack
);

    typedef struct packed {
        logic [7:0]            psel;
        logic [3:0][7:0][6:0]  tgt;
        logic [3:0][7:0][7:0]  als;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic                  fwd_valid;
        logic [1:0]            fwd_port;
        logic [6:0]            fwd_addr;
        logic                  fwd_rnw;
        logic [2:0]            fwd_slot;
        logic                  fwd_auto;
        logic                  miss;
        logic                  pend;
        logic                  ack_valid;
        logic                  ack;
    } rar_state_s;

    rar_state_s q;
    rar_state_s d;
    logic       hit;
    logic [2:0] hit_slot;
    logic [1:0] sel_port;

    // =================================================================
    // address decode helpers
    // =================================================================
    function automatic logic in_range(input logic [7:0] a,
                                      input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [2:0] slot_of(input logic [7:0] a,
                                           input logic [7:0] base);
        logic [7:0] diff;
        diff = a - base;
        return diff[2:0];
    endfunction

    assign sel_port = q.psel[1:0];

    // =================================================================
    // alias decode
    // =================================================================
    rar_alias_match u_match (
        .alias_tbl (q.als[txn_port]),
        .addr      (txn_addr),
        .hit       (hit),
        .slot      (hit_slot)
    );

    // =================================================================
    // next state
    // =================================================================
    always_comb begin
        d           = q;
        d.rvalid    = 1'b0;
        d.rdata     = 8'h00;
        d.fwd_valid = 1'b0;
        d.miss      = 1'b0;
        d.ack_valid = 1'b0;
        d.ack       = 1'b0;
        // target and alias writes land in the copy of the selected port only
        if (reg_wr) begin
            if (reg_addr == rar_pkg::PORT_SEL_OFS) begin
                d.psel = reg_wdata & rar_pkg::PSEL_MASK;
            end else if (in_range(reg_addr, rar_pkg::TGT_BASE,
                                  rar_pkg::TGT_END)) begin
                // bit 0 is dropped here
                d.tgt[sel_port][slot_of(reg_addr, rar_pkg::TGT_BASE)] =
                    reg_wdata[rar_pkg::ADDR_MSB:rar_pkg::ADDR_LSB];
            end else if (in_range(reg_addr, rar_pkg::ALIAS_BASE,
                                  rar_pkg::ALIAS_END)) begin
                d.als[sel_port][slot_of(reg_addr, rar_pkg::ALIAS_BASE)] =
                    reg_wdata;
            end
        end
        // reads answer one cycle later; unmapped offsets read zero
        if (reg_rd) begin
            d.rvalid = 1'b1;
            if (reg_addr == rar_pkg::PORT_SEL_OFS) begin
                d.rdata = q.psel;
            end else if (in_range(reg_addr, rar_pkg::TGT_BASE,
                                  rar_pkg::TGT_END)) begin
                d.rdata = {q.tgt[sel_port][slot_of(reg_addr,
                           rar_pkg::TGT_BASE)], 1'b0};
            end else if (in_range(reg_addr, rar_pkg::ALIAS_BASE,
                                  rar_pkg::ALIAS_END)) begin
                d.rdata = q.als[sel_port][slot_of(reg_addr,
                           rar_pkg::ALIAS_BASE)];
            end
        end
        // address phase: remap a hit, refuse a miss with a nack
        if (txn_valid) begin
            if (hit) begin
                d.fwd_valid = 1'b1;
                d.fwd_port  = txn_port;
                d.fwd_slot  = hit_slot;
                d.fwd_addr  = q.tgt[txn_port][hit_slot];
                d.fwd_rnw   = txn_rnw;
                d.fwd_auto  = !txn_rnw &&
                    q.als[txn_port][hit_slot][rar_pkg::AUTO_ACK_BIT];
                if (d.fwd_auto) begin
                    d.ack_valid = 1'b1;
                    d.ack       = 1'b1;
                    d.pend      = 1'b0;
                end else begin
                    d.pend      = 1'b1;
                end
            end else begin
                d.miss      = 1'b1;
                d.ack_valid = 1'b1;
                d.pend      = 1'b0;
            end
        end else if (q.pend && remote_ack_valid) begin
            // without auto ack the host waits on the far end's answer
            d.pend      = 1'b0;
            d.ack_valid = 1'b1;
            d.ack       = remote_ack;
        end
    end

    // =================================================================
    // state register
    // =================================================================
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q      <= '0;
            q.psel <= rar_pkg::PORT_SEL_RST;
        end else begin
            q <= d;
        end
    end

    // outputs come straight from the state flops
    assign reg_rvalid     = q.rvalid;
    assign reg_rdata      = q.rdata;
    assign fwd_valid      = q.fwd_valid;
    assign fwd_port       = q.fwd_port;
    assign fwd_addr       = q.fwd_addr;
    assign fwd_rnw        = q.fwd_rnw;
    assign fwd_slot       = q.fwd_slot;
    assign fwd_auto_ack   = q.fwd_auto;
    assign txn_miss       = q.miss;
    assign host_ack_valid = q.ack_valid;
    assign host_ack       = q.ack;

    // =================================================================
    // checks
    // =================================================================
    logic [6:0] exp_tgt;
    logic       exp_auto;
    logic [1:0] other_port;
    logic [6:0] hit_field;
    logic [6:0] wr_field;
    logic [7:0] other_als0;

    assign exp_tgt    = q.tgt[txn_port][hit_slot];
    assign exp_auto   = q.als[txn_port][hit_slot][0];
    assign other_port = sel_port + 2'h1;
    // plain signals so that each past value names one net
    assign hit_field  =
        q.als[txn_port][hit_slot][rar_pkg::ADDR_MSB:rar_pkg::ADDR_LSB];
    assign wr_field   = reg_wdata[rar_pkg::ADDR_MSB:rar_pkg::ADDR_LSB];
    assign other_als0 = q.als[other_port][0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_remap_addr;
        txn_valid && hit |=> fwd_valid && fwd_addr == $past(exp_tgt)
            && fwd_slot == $past(hit_slot);
    endproperty
    a_remap_addr: assert property (p_remap_addr)
        else $error("forwarded address is not the paired target");

    property p_miss_nack;
        txn_valid && !hit |=> !fwd_valid && txn_miss
            && host_ack_valid && !host_ack;
    endproperty
    a_miss_nack: assert property (p_miss_nack)
        else $error("unmatched address was not refused");

    // address zero could only hit a cleared slot, so it must be refused
    property p_zero_alias;
        txn_valid && txn_addr == rar_pkg::ADDR_OFF
            |=> !fwd_valid && txn_miss;
    endproperty
    a_zero_alias: assert property (p_zero_alias)
        else $error("transaction forwarded through a disabled alias");

    property p_auto_ack;
        txn_valid && hit && !txn_rnw && exp_auto
            |=> host_ack_valid && host_ack && fwd_auto_ack;
    endproperty
    a_auto_ack: assert property (p_auto_ack)
        else $error("auto acknowledge missing for write");

    property p_no_auto_ack;
        txn_valid && hit && (txn_rnw || !exp_auto)
            |=> !host_ack_valid ##1 (q.pend || host_ack_valid);
    endproperty
    a_no_auto_ack: assert property (p_no_auto_ack)
        else $error("acknowledge given without remote answer");

    property p_rsvd_zero;
        reg_rd && in_range(reg_addr, rar_pkg::TGT_BASE, rar_pkg::TGT_END)
            |=> reg_rvalid && !reg_rdata[0];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved target bit read as one");

    property p_tgt_store;
        reg_wr && reg_addr == rar_pkg::TGT_SLOT7
            |=> q.tgt[$past(sel_port)][7] == $past(wr_field);
    endproperty
    a_tgt_store: assert property (p_tgt_store)
        else $error("target field not stored from bits 7:1");

    property p_port_isolate;
        reg_wr && reg_addr == rar_pkg::ALIAS_BASE
            |=> q.als[$past(sel_port)][0] == $past(reg_wdata)
            && q.als[$past(other_port)][0] == $past(other_als0);
    endproperty
    a_port_isolate: assert property (p_port_isolate)
        else $error("alias write reached the wrong port copy");

    // the slot handed on must be the one whose alias equals the address
    property p_pair_index;
        txn_valid && hit |-> hit_field == txn_addr
            ##1 fwd_valid && fwd_slot == $past(hit_slot);
    endproperty
    a_pair_index: assert property (p_pair_index)
        else $error("alias slot paired with wrong target slot");

    c_auto_write: cover property (txn_valid && hit && !txn_rnw
                                  && exp_auto);
    c_remote_ack: cover property (q.pend && remote_ack_valid);
    c_miss:       cover property (txn_valid && !hit);
    c_reg_read:   cover property (reg_rd && reg_addr == rar_pkg::ALIAS_SLOT2);

endmodule

// ---- testbench/rar_ser_model.sv ----
// =====================================================================
// serializer side model: answers every forwarded transaction
// =====================================================================
// assumes fwd_valid is a one-cycle pulse on clk_sys; answer and delay
// are chosen by the bench before each transaction.
`timescale 1ns/100ps

module rar_ser_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // forward seen, answer and delay set by the bench
    input  wire logic       fwd_valid,
    input  wire logic       ack_val,
    input  wire logic [2:0] dly,
    // answer toward the block
    output logic            remote_ack_valid,
    output logic            remote_ack
);
    logic       busy_q;
    logic       ack_q;
    logic [2:0] cnt_q;

    // answers auto-acked writes too, as a real far end would
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_q           <= 1'b0;
            ack_q            <= 1'b0;
            cnt_q            <= 3'h0;
            remote_ack_valid <= 1'b0;
            remote_ack       <= 1'b0;
        end else begin
            remote_ack_valid <= 1'b0;
            remote_ack       <= ~remote_ack; // junk outside the strobe
            if (fwd_valid) begin
                busy_q <= 1'b1;
                ack_q  <= ack_val;
                cnt_q  <= dly;
            end else if (busy_q && cnt_q == 3'h0) begin
                busy_q           <= 1'b0;
                remote_ack_valid <= 1'b1;
                remote_ack       <= ack_q;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 3'h1;
            end
        end
    end
endmodule

// ---- testbench/test_remote_i2c_alias_remap.sv ----
// =====================================================================
// bench for the alias remap block
// =====================================================================
// drivers note expected results in queues; a monitor compares them.
// assumes one transaction in flight and the serializer model beside.
`timescale 1ns/100ps

module test_remote_i2c_alias_remap;
    logic        clk_sys, rstn, reg_wr, reg_rd, reg_rvalid, txn_valid;
    logic        txn_rnw, fwd_valid, fwd_rnw, fwd_auto_ack, txn_miss;
    logic        remote_ack_valid, remote_ack, host_ack_valid, host_ack;
    logic        p_ack;
    logic [1:0]  txn_port, fwd_port;
    logic [2:0]  fwd_slot, p_dly;
    logic [6:0]  txn_addr, fwd_addr;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [7:0]  alias_m [4][8];
    logic [7:0]  tgt_m [4][8];
    logic [7:0]  q_rd [$];
    logic [13:0] q_fwd [$];
    logic [1:0]  q_ack [$];
    logic [31:0] r;
    int          n_errors, total_checks, seed, cyc;
    int          sl [4] = '{0, 1, 2, 7};

    rar_remap dut_u (
        .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .txn_valid(txn_valid), .txn_port(txn_port),
        .txn_addr(txn_addr), .txn_rnw(txn_rnw), .fwd_valid(fwd_valid),
        .fwd_port(fwd_port), .fwd_addr(fwd_addr), .fwd_rnw(fwd_rnw),
        .fwd_slot(fwd_slot), .fwd_auto_ack(fwd_auto_ack),
        .txn_miss(txn_miss), .remote_ack_valid(remote_ack_valid),
        .remote_ack(remote_ack), .host_ack_valid(host_ack_valid),
        .host_ack(host_ack));

    rar_ser_model ser_u (
        .clk_sys(clk_sys), .rstn(rstn), .fwd_valid(fwd_valid),
        .ack_val(p_ack), .dly(p_dly),
        .remote_ack_valid(remote_ack_valid), .remote_ack(remote_ack));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // =================================================================
    // compare tasks and closing report
    // =================================================================
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] reg_rdata expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_fwd(input logic [13:0] e, input logic [13:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] forward expected %h seen %h", e, g);
        end
    endtask

    task automatic chk_ack(input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] miss_ack expected %b seen %b", e, g);
        end
    endtask

    task automatic end_of_test();
        // a note never answered is a missing result
        if (q_rd.size() + q_fwd.size() + q_ack.size() != 0) n_errors++;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =================================================================
    // drivers
    // =================================================================
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        q_rd.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask

    // lowest enabled slot whose field equals the address wins
    task automatic txn(input logic [1:0] p, input logic [6:0] a,
                       input logic rnw);
        int          s;
        logic        au;
        logic [31:0] x;
        s = -1;
        x = $random(seed);
        for (int n = 7; n >= 0; n--)
            if (alias_m[p][n][7:1] != 7'h00 && alias_m[p][n][7:1] == a) s = n;
        if (s < 0) begin
            q_ack.push_back(2'b10);
        end else begin
            au = !rnw && alias_m[p][s][0];
            q_fwd.push_back({p, tgt_m[p][s][7:1], rnw, 3'(s), au});
            q_ack.push_back({1'b0, au | x[0]});
        end
        @(posedge clk_sys);
        p_ack     <= x[0];
        p_dly     <= x[3:1];
        txn_port  <= p;
        txn_addr  <= a;
        txn_rnw   <= rnw;
        txn_valid <= 1'b1;
        @(posedge clk_sys);
        txn_valid <= 1'b0;
        repeat (16) begin
            @(negedge clk_sys);
            if (host_ack_valid === 1'b1) break;
        end
        // let a late answer after an auto ack die out before the next
        repeat (10) @(posedge clk_sys);
    endtask

    // =================================================================
    // monitor: each result takes the oldest note of its kind
    // =================================================================
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (q_rd.size() == 0) q_rd.push_back('x);
            chk_rd(q_rd.pop_front(), reg_rdata);
        end
        if (fwd_valid === 1'b1) begin
            if (q_fwd.size() == 0) q_fwd.push_back('x);
            chk_fwd(q_fwd.pop_front(), {fwd_port, fwd_addr, fwd_rnw,
                    fwd_slot, fwd_auto_ack});
        end
        if (host_ack_valid === 1'b1) begin
            if (q_ack.size() == 0) q_ack.push_back('x);
            chk_ack(q_ack.pop_front(), {txn_miss, host_ack});
        end
    end

    // hang guard sized well above the planned traffic
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_errors++;
            end_of_test();
        end
    end

    // =================================================================
    // main sequence
    // =================================================================
    initial begin
        seed = 85;
        {n_errors, total_checks, cyc} = '0;
        {rstn, reg_wr, reg_rd, txn_valid, txn_rnw, p_ack} = '0;
        {txn_port, p_dly, txn_addr, reg_addr, reg_wdata} = '0;
        foreach (alias_m[p, n]) alias_m[p][n] = rar_pkg::SLOT_RST;
        foreach (tgt_m[p, n]) tgt_m[p][n] = rar_pkg::SLOT_RST;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        // reset values, plus an unmapped offset that reads zero
        for (int a = 8'h64; a <= 8'h67; a++) rd(8'(a), 8'h00);
        rd(8'h70, 8'h00);
        $display("test reset_values done");
        for (int p = 0; p < 4; p++) begin
            r = $random(seed);
            wr(rar_pkg::PORT_SEL_OFS, {r[7:2], 2'(p)});
            rd(rar_pkg::PORT_SEL_OFS, {6'h00, 2'(p)});
            foreach (sl[k]) begin
                r = $random(seed);
                tgt_m[p][sl[k]] = r[7:0];
                alias_m[p][sl[k]] = {2'b01, 2'(p), 3'(sl[k]), r[8]};
                wr(8'(rar_pkg::TGT_BASE + sl[k]), tgt_m[p][sl[k]]);
                wr(8'(rar_pkg::ALIAS_BASE + sl[k]), alias_m[p][sl[k]]);
            end
        end
        // read back only after every port is written: copies stay apart
        for (int p = 0; p < 4; p++) begin
            wr(rar_pkg::PORT_SEL_OFS, 8'(p));
            foreach (sl[k]) begin
                rd(8'(rar_pkg::TGT_BASE + sl[k]),
                   tgt_m[p][sl[k]] & 8'hfe);
                rd(8'(rar_pkg::ALIAS_BASE + sl[k]), alias_m[p][sl[k]]);
            end
        end
        $display("test register_copies done");
        for (int w = 0; w < 2; w++)
            for (int p = 0; p < 4; p++)
                foreach (sl[k])
                    txn(2'(p), alias_m[p][sl[k]][7:1], w[0]);
        $display("test remap_and_ack done");
        for (int p = 0; p < 4; p++) begin
            txn(2'(p), 7'h00, 1'b0);
            txn(2'(p), alias_m[p ^ 1][0][7:1], 1'b1);
        end
        // clear an alias field with auto ack left on: slot must go dead
        wr(rar_pkg::PORT_SEL_OFS, 8'h02);
        wr(rar_pkg::ALIAS_SLOT1, 8'h01);
        alias_m[2][1] = 8'h01;
        txn(2'h2, {2'b01, 2'h2, 3'h1}, 1'b0);
        $display("test misses done");
        // same alias on slot 7 of port 3: the lower slot keeps the traffic
        wr(rar_pkg::PORT_SEL_OFS, 8'h03);
        alias_m[3][7] = alias_m[3][0];
        wr(8'(rar_pkg::ALIAS_BASE + 7), alias_m[3][7]);
        txn(2'h3, alias_m[3][0][7:1], 1'b1);
        $display("test duplicate_alias done");
        repeat (4) @(posedge clk_sys);
        end_of_test();
    end
endmodule
